// ### logic/scti_pkg.sv
/*
 * Package for the smart-card timer and interrupt block: register offsets,
 * field positions, reset values and widths.
 * Assumes a 32-bit AHB-Lite register bus with one word per register.
 */
package scti_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_IRQ = 8'h04;
	localparam logic [7:0] OFS_GUARD = 8'h08;
	localparam logic [7:0] OFS_WAIT_LO = 8'h0c;
	localparam logic [7:0] OFS_WAIT_HI = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_CLEAR = 8'h18;
	localparam logic [7:0] OFS_ETU_DIV = 8'h1c;
	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTL_CARD_EN = 0;
	localparam int CTL_PROTO = 1;
	localparam int CTL_LOGIC_CONVENTION_SELECT = 3;
	localparam int CTL_RPT_LO = 4;
	localparam int CTL_PORT_EN = 15;
	// ----------------------------------------------------------------
	// Interrupt register fields (flags high byte, enables low byte)
	// ----------------------------------------------------------------
	localparam int IRQ_GUARD_F = 8;
	localparam int IRQ_WAIT_F = 9;
	localparam int IRQ_RESEND_COUNT_SELECT_F = 12;
	localparam int IRQ_RXRPT_F = 13;
	localparam int IRQ_GUARD_E = 0;
	localparam int IRQ_WAIT_E = 1;
	localparam int IRQ_RESEND_COUNT_SELECT_E = 4;
	localparam int IRQ_RXRPT_E = 5;
	localparam int IRQ_PAR_E = 6;
	localparam logic [15:0] IRQ_RW_MASK = 16'h0073;
	// Status bit positions: 0 guard, 1 wait, 2 tx repeat, 3 rx repeat,
	// 4 parity
	localparam int NUM_EVENTS = 5;
	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int GUARD_W = 9;
	localparam int WAIT_W = 24;
	localparam int DIV_W = 16;
	localparam logic [15:0] ETU_DIV_RESET = 16'h0173;
	localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : scti_pkg

// ### logic/scti_top.sv
/*
 * Smart-card guard-time and waiting-time counters with their interrupt
 * flags, enables and an AHB-Lite register slave.
 * Assumes the UART core supplies one-cycle event pulses for line errors
 * and repeats, and that a single master drives the bus.
 */
// Our own choices: the register addresses and the AHB-Lite register port.
// Behaviour
// - Guard count holds nine writable bits; bits 15..9 read zero.
// - Waiting count low register holds bits 15..0, fully writable.
// - Waiting high register holds bits 23..16; upper byte reads zero.
// - Both counters step once per elementary time unit bit clock.
// - Registers exist only in the first two serial port instances.
// - Repeat flags and parity/repeat enables act only under T=0.
// - Two-bit resend field: codes 00..11 resend once to four times.
// - Card mode active only when card and port enables both set.
// - Convention select one means inverse, zero direct convention.
`timescale 1ns/1ps
module scti_top
	import scti_pkg::*;
#(
	parameter int INSTANCE = 0
)
(
	input wire logic I_REF_CLK,
	input wire logic I_RESET,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	input wire logic I_TX_ERROR,
	input wire logic I_RX_REPEAT,
	input wire logic I_PARITY_ERROR,
	output logic [31:0] O_HRDATA,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	output logic O_CARD_ACTIVE,
	output logic O_PROTOCOL_T1,
	output logic O_INVERSE_LOGIC_CONVENTION_SELECT,
	output logic [2:0] O_RESEND_TIMES,
	output logic O_ETU_TICK,
	output logic O_IRQ
);
	import scti_pkg::*;

	// Registers live only in ports 0 and 1
	localparam bit PRESENT = (INSTANCE < 2);

	logic [15:0] ctl_q;
	logic [6:0] ien_q;
	logic [GUARD_W-1:0] guard_q;
	logic [WAIT_W-1:0] wait_q;
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_cnt_q;
	logic [NUM_EVENTS-1:0] stat_q;
	logic [NUM_EVENTS-1:0] stat_d;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] rdata_q;

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	wire card_active = PRESENT && ctl_q[CTL_CARD_EN]
		&& ctl_q[CTL_PORT_EN];
	wire proto_t1 = ctl_q[CTL_PROTO];
	wire t0_active = card_active && !proto_t1;
	wire [1:0] rpt_code = ctl_q[CTL_RPT_LO+1:CTL_RPT_LO];

	assign O_CARD_ACTIVE = card_active;
	assign O_PROTOCOL_T1 = proto_t1;
	assign O_INVERSE_LOGIC_CONVENTION_SELECT = ctl_q[CTL_LOGIC_CONVENTION_SELECT];
	assign O_RESEND_TIMES = {1'b0, rpt_code} + 3'h1;

	// ----------------------------------------------------------------
	// Bit clock divider
	// ----------------------------------------------------------------
	// One enable pulse per ETU; the counters never run on another clock
	wire etu_tick = card_active && (div_cnt_q == '0);
	assign O_ETU_TICK = etu_tick;

	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET || !card_active || etu_tick)
			div_cnt_q <= div_q;
		else
			div_cnt_q <= div_cnt_q - 16'h0001;
	end

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire addr_ph = I_HSEL && I_HREADY && (I_HTRANS == HTRANS_NONSEQ);
	wire rd_ph = addr_ph && !I_HWRITE;
	wire wr_ph = addr_ph && I_HWRITE;
	wire [7:0] a8 = I_HADDR[7:0];
	wire w_ctl = wr_pend_q && (wr_addr_q == OFS_CONTROL);
	wire w_irq = wr_pend_q && (wr_addr_q == OFS_IRQ);
	wire w_guard = wr_pend_q && (wr_addr_q == OFS_GUARD);
	wire w_wlo = wr_pend_q && (wr_addr_q == OFS_WAIT_LO);
	wire w_whi = wr_pend_q && (wr_addr_q == OFS_WAIT_HI);
	wire w_clr = wr_pend_q && (wr_addr_q == OFS_CLEAR);
	wire w_div = wr_pend_q && (wr_addr_q == OFS_ETU_DIV);

	assign O_HREADYOUT = 1'b1;
	assign O_HRESP = 1'b0;
	assign O_HRDATA = rdata_q;

	// Interrupt register view: flags high byte, enables low byte
	wire [15:0] irq_view = {2'b00, stat_q[3], stat_q[2], 2'b00,
		stat_q[1], stat_q[0], 1'b0, ien_q[6:4], 2'b00, ien_q[1:0]};

	function automatic logic [31:0] read_mux(input logic [7:0] a);
		logic [31:0] r;
		r = RESET_ZERO;
		if (PRESENT)
		begin
			unique case (a)
				OFS_CONTROL: r = {16'h0000, ctl_q};
				OFS_IRQ: r = {16'h0000, irq_view};
				OFS_GUARD: r = {23'h000000, guard_q};
				OFS_WAIT_LO: r = {16'h0000, wait_q[15:0]};
				OFS_WAIT_HI: r = {24'h000000, wait_q[23:16]};
				OFS_STATUS: r = {27'h0000000, stat_q};
				OFS_ETU_DIV: r = {16'h0000, div_q};
				default: r = RESET_ZERO;
			endcase
		end
		return r;
	endfunction : read_mux

	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			rdata_q <= RESET_ZERO;
		end
		else
		begin
			wr_pend_q <= wr_ph && PRESENT;
			wr_addr_q <= a8;
			rdata_q <= rd_ph ? read_mux(a8) : RESET_ZERO;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			ctl_q <= 16'h0000;
			ien_q <= 7'h00;
			div_q <= ETU_DIV_RESET;
		end
		else
		begin
			if (w_ctl)
				ctl_q <= I_HWDATA[15:0] & 16'h803b;
			if (w_irq)
				ien_q <= I_HWDATA[6:0] & IRQ_RW_MASK[6:0];
			if (w_div)
				div_q <= I_HWDATA[15:0];
		end
	end

	// ----------------------------------------------------------------
	// Guard and waiting counters
	// ----------------------------------------------------------------
	// Counters load by write and count down to zero, then hold
	// A write in the tick cycle wins, so a reload never raises a flag
	wire guard_zero_ev = etu_tick && !w_guard
		&& (guard_q == 9'h001);
	wire wait_zero_ev = etu_tick && !w_wlo && !w_whi
		&& (wait_q == 24'h000001);

	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
		begin
			guard_q <= '0;
			wait_q <= '0;
		end
		else
		begin
			if (w_guard)
				guard_q <= I_HWDATA[8:0];
			else if (etu_tick && guard_q != '0)
				guard_q <= guard_q - 9'h001;
			if (w_wlo)
				wait_q[15:0] <= I_HWDATA[15:0];
			if (w_whi)
				wait_q[23:16] <= I_HWDATA[7:0];
			if (!w_wlo && !w_whi && etu_tick && wait_q != '0)
				wait_q <= wait_q - 24'h000001;
		end
	end

	// ----------------------------------------------------------------
	// Sticky status, clear register and interrupt output
	// ----------------------------------------------------------------
	// Repeat and parity events are ignored under T=1
	wire [NUM_EVENTS-1:0] ev = {I_PARITY_ERROR && t0_active,
		I_RX_REPEAT && t0_active, I_TX_ERROR && t0_active,
		wait_zero_ev, guard_zero_ev};
	wire [NUM_EVENTS-1:0] clr = w_clr ? I_HWDATA[NUM_EVENTS-1:0] : '0;
	wire [NUM_EVENTS-1:0] en_v = {ien_q[6] && t0_active,
		ien_q[5] && t0_active, ien_q[4] && t0_active,
		ien_q[1], ien_q[0]};

	// A set arriving with its clear wins, so no event is lost
	always_comb
	begin
		stat_d = (stat_q & ~clr) | ev;
	end

	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RESET)
			stat_q <= '0;
		else
			stat_q <= stat_d;
	end

	assign O_IRQ = |(stat_q & en_v);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_guard_last;
		etu_tick && !w_guard && guard_q == 9'h001;
	endsequence

	chk_guard_flag_set: assert property (@(posedge I_REF_CLK)
		disable iff (I_RESET) s_guard_last |=> stat_q[0])
		else $error("guard flag not set at zero");

	chk_wait_flag_set: assert property (@(posedge I_REF_CLK)
		disable iff (I_RESET)
		etu_tick && !w_wlo && !w_whi && wait_q == 24'h000001
		|=> stat_q[1] && wait_q == '0)
		else $error("wait flag not set at zero");

	chk_irq_follows: assert property (@(posedge I_REF_CLK)
		disable iff (I_RESET) O_IRQ == |(stat_q & en_v))
		else $error("interrupt does not match enabled flags");

	chk_tick_needs_en: assert property (@(posedge I_REF_CLK)
		disable iff (I_RESET)
		etu_tick |-> ctl_q[CTL_CARD_EN] && ctl_q[CTL_PORT_EN])
		else $error("bit clock ran while card mode off");

	chk_tick_spacing: assert property (@(posedge I_REF_CLK)
		disable iff (I_RESET) etu_tick && div_q != '0 |=> !etu_tick)
		else $error("bit clock pulses back to back");

	chk_wait_step: assert property (@(posedge I_REF_CLK)
		disable iff (I_RESET)
		!etu_tick && !w_wlo && !w_whi |=> wait_q == $past(wait_q))
		else $error("wait count moved without bit clock");

	chk_guard_step: assert property (@(posedge I_REF_CLK)
		disable iff (I_RESET)
		!etu_tick && !w_guard |=> guard_q == $past(guard_q))
		else $error("guard count moved without bit clock");

	chk_t1_no_rpt: assert property (@(posedge I_REF_CLK)
		disable iff (I_RESET) proto_t1 && !stat_q[2] |=> !stat_q[2])
		else $error("tx repeat flag set under T=1");

	chk_t1_no_parity: assert property (@(posedge I_REF_CLK)
		disable iff (I_RESET) proto_t1 && !stat_q[4] |=> !stat_q[4])
		else $error("parity flag set under T=1");

	chk_t1_rpt_hold: assert property (@(posedge I_REF_CLK)
		disable iff (I_RESET) proto_t1 && !stat_q[3] |=> !stat_q[3])
		else $error("rx repeat flag set under T=1");

	chk_guard_hi_zero: assert property (@(posedge I_REF_CLK)
		disable iff (I_RESET)
		rd_ph && a8 == OFS_GUARD |=> O_HRDATA[31:9] == '0)
		else $error("guard upper bits not zero");

	chk_wait_hi_zero: assert property (@(posedge I_REF_CLK)
		disable iff (I_RESET)
		rd_ph && a8 == OFS_WAIT_HI |=> O_HRDATA[31:8] == '0)
		else $error("wait high upper byte not zero");

	chk_resend_map: assert property (@(posedge I_REF_CLK)
		disable iff (I_RESET)
		(rpt_code == 2'b00 && O_RESEND_TIMES == 3'h1)
		|| (rpt_code == 2'b01 && O_RESEND_TIMES == 3'h2)
		|| (rpt_code == 2'b10 && O_RESEND_TIMES == 3'h3)
		|| (rpt_code == 2'b11 && O_RESEND_TIMES == 3'h4))
		else $error("resend count mapping wrong");

	chk_set_wins: assert property (@(posedge I_REF_CLK)
		disable iff (I_RESET)
		(ev & clr) != '0 |=> (stat_q & $past(ev & clr)) == $past(ev & clr))
		else $error("clear beat a same-cycle event");
endmodule : scti_top

// ### testbench/scti_card_model.sv
/*
 * Card-side model: turns a bench command into one-cycle event pulses.
 * Assumes commands change just after a rising edge and last one cycle.
 */
`timescale 1ns/1ps
module scti_card_model
(
	input wire logic i_clk,
	input wire logic [2:0] i_cmd,
	output logic o_tx_error = 1'b0,
	output logic o_rx_repeat = 1'b0,
	output logic o_parity_error = 1'b0
);
	// Registered so each pulse spans exactly one clock, like the core's
	always_ff @(posedge i_clk)
	begin
		o_tx_error <= i_cmd[0];
		o_rx_repeat <= i_cmd[1];
		o_parity_error <= i_cmd[2];
	end
endmodule : scti_card_model

// ### testbench/scti_tb_top.sv
/*
 * Self-checking bench for the smart-card timer block over AHB-Lite.
 * Assumes a zero-wait slave; waits on hready anyway.
 */
`timescale 1ns/1ps
module smart_card_timers_interrupts_tb_top;
	import scti_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [2:0] cmd = 3'h0;
	logic hready, irq, act, t1, inv, tick, txe, rxr, par, rdy2, rsp, rsp2;
	logic [2:0] rpt;
	logic [31:0] hrdata, hrdata2, rd2;
	int errors = 0;
	int samples_checked = 0;
	// ------------------------------------------------------------
	// Design instances and card model
	// ------------------------------------------------------------
	scti_top scti_top_inst (.I_REF_CLK(clk), .I_RESET(rst), .I_HSEL(1'b1),
		.I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
		.I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
		.I_TX_ERROR(txe), .I_RX_REPEAT(rxr), .I_PARITY_ERROR(par),
		.O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(rsp),
		.O_CARD_ACTIVE(act), .O_PROTOCOL_T1(t1), .O_INVERSE_LOGIC_CONVENTION_SELECT(inv),
		.O_RESEND_TIMES(rpt), .O_ETU_TICK(tick), .O_IRQ(irq));
	// A third port instance: registers must be absent there
	scti_top #(.INSTANCE(2)) scti_top_inst2 (.I_REF_CLK(clk), .I_RESET(rst),
		.I_HSEL(1'b1), .I_HADDR(haddr), .I_HTRANS(htrans),
		.I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
		.I_HREADY(hready), .I_TX_ERROR(txe), .I_RX_REPEAT(rxr),
		.I_PARITY_ERROR(par), .O_HRDATA(hrdata2), .O_HREADYOUT(rdy2),
		.O_HRESP(rsp2), .O_CARD_ACTIVE(), .O_PROTOCOL_T1(),
		.O_INVERSE_LOGIC_CONVENTION_SELECT(), .O_RESEND_TIMES(), .O_ETU_TICK(), .O_IRQ());
	scti_card_model scti_card_model_inst (.i_clk(clk), .i_cmd(cmd),
		.o_tx_error(txe), .o_rx_repeat(rxr), .o_parity_error(par));
	initial
	begin
		forever #2 clk = ~clk;
	end
	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		r = hrdata;
		rd2 = hrdata2;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		check(r, e);
	endtask : rd
	task automatic pulse(input logic [2:0] c);
		cmd <= c;
		@(posedge clk);
		cmd <= 3'h0;
		repeat (2) @(posedge clk);
	endtask : pulse
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		rd(OFS_CONTROL, 32'h0);
		rd(OFS_IRQ, 32'h0);
		rd(OFS_GUARD, 32'h0);
		rd(OFS_WAIT_LO, 32'h0);
		rd(OFS_WAIT_HI, 32'h0);
		rd(OFS_STATUS, 32'h0);
		rd(OFS_ETU_DIV, {16'h0, ETU_DIV_RESET});
		rd(8'h40, 32'h0);
		check({31'h0, irq}, 32'h0);
		check({30'h0, rsp, rsp2}, 32'h0);
		check({31'h0, rdy2}, 32'h1);
		$display("reset values done");
	endtask : t_reset
	task automatic t_widths;
		wr(OFS_GUARD, 32'hffff_ffff);
		rd(OFS_GUARD, 32'h1ff);
		check(rd2, 32'h0);
		wr(OFS_WAIT_LO, 32'hffff_ffff);
		rd(OFS_WAIT_LO, 32'hffff);
		wr(OFS_WAIT_HI, 32'hffff_ffff);
		rd(OFS_WAIT_HI, 32'hff);
		check(rd2, 32'h0);
		wr(OFS_IRQ, 32'hffff_ffff);
		rd(OFS_IRQ, {16'h0, IRQ_RW_MASK});
		wr(OFS_IRQ, 32'h0);
		$display("register widths done");
	endtask : t_widths
	task automatic t_ctrl;
		for (int c = 0; c < 4; c++)
		begin
			wr(OFS_CONTROL, 32'h8001 | (c << 4) | ((c & 1) << 1) | ((c & 2) << 2));
			@(posedge clk);
			check({29'h0, rpt}, c + 1);
			check({31'h0, t1}, c & 1);
			check({31'h0, inv}, (c >> 1) & 1);
			check({31'h0, act}, 32'h1);
		end
		wr(OFS_CONTROL, 32'h0001);
		@(posedge clk);
		check({31'h0, act}, 32'h0);
		wr(OFS_CONTROL, 32'h8000);
		@(posedge clk);
		check({31'h0, act}, 32'h0);
		$display("control fields done");
	endtask : t_ctrl
	task automatic t_count;
		int n, cyc, c1, c2;
		n = 0;
		c1 = 0;
		c2 = 0;
		wr(OFS_ETU_DIV, 32'h3);
		wr(OFS_GUARD, 32'h2);
		wr(OFS_CLEAR, 32'h1f);
		wr(OFS_IRQ, 32'h1);
		wr(OFS_CONTROL, 32'h8001);
		for (cyc = 0; cyc < 200 && irq !== 1'b1; cyc++)
		begin
			@(posedge clk);
			if (tick === 1'b1)
			begin
				n++;
				c1 = (n == 1) ? cyc : c1;
				c2 = (n == 2) ? cyc : c2;
			end
		end
		check(c2 - c1, 32'h4);
		check(n, 32'h2);
		check({31'h0, irq}, 32'h1);
		rd(OFS_STATUS, 32'h1);
		wr(OFS_IRQ, 32'h0);
		@(posedge clk);
		check({31'h0, irq}, 32'h0);
		wr(OFS_IRQ, 32'h1);
		wr(OFS_GUARD, 32'h1ff);
		check({31'h0, irq}, 32'h1);
		wr(OFS_CLEAR, 32'h1);
		@(posedge clk);
		check({31'h0, irq}, 32'h0);
		$display("guard count done");
	endtask : t_count
	task automatic t_events;
		wr(OFS_IRQ, 32'h70);
		wr(OFS_CONTROL, 32'h8003);
		pulse(3'h7);
		rd(OFS_STATUS, 32'h0);
		wr(OFS_CONTROL, 32'h0001);
		pulse(3'h7);
		rd(OFS_STATUS, 32'h0);
		wr(OFS_CONTROL, 32'h8001);
		pulse(3'h7);
		rd(OFS_STATUS, 32'h1c);
		check({31'h0, irq}, 32'h1);
		rd(OFS_IRQ, 32'h3070);
		// Event and clear reach the status in the same cycle: set wins
		fork
			pulse(3'h1);
			wr(OFS_CLEAR, 32'h1c);
		join
		rd(OFS_STATUS, 32'h4);
		wr(OFS_CLEAR, 32'h1c);
		@(posedge clk);
		check({31'h0, irq}, 32'h0);
		$display("card events done");
	endtask : t_events
	task automatic t_wait;
		int cyc;
		wr(OFS_CONTROL, 32'h8001);
		wr(OFS_IRQ, 32'h2);
		wr(OFS_WAIT_HI, 32'h0);
		wr(OFS_WAIT_LO, 32'h3);
		for (cyc = 0; cyc < 200 && irq !== 1'b1; cyc++)
			@(posedge clk);
		check({31'h0, irq}, 32'h1);
		rd(OFS_STATUS, 32'h2);
		rd(OFS_WAIT_LO, 32'h0);
		rd(OFS_WAIT_HI, 32'h0);
		wr(OFS_CLEAR, 32'h2);
		@(posedge clk);
		check({31'h0, irq}, 32'h0);
		$display("waiting count done");
	endtask : t_wait
	// ------------------------------------------------------------
	// Sequence, watchdog and verdict
	// ------------------------------------------------------------
	task automatic finish_test;
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_widths();
		t_ctrl();
		t_count();
		t_events();
		t_wait();
		finish_test();
	end
	initial
	begin
		#40000;
		errors++;
		finish_test();
	end
endmodule : smart_card_timers_interrupts_tb_top
